// *** pkg/idx_decode_pkg.sv ***
// constants for the indexed literal offset decode and execute path
package idx_decode_pkg;
  // opcode patterns (upper byte; add and bit-set masked, fill exact)
  localparam logic [7:0] ADD_MASK = 8'hfd;
  localparam logic [7:0] ADD_PATTERN = 8'h24;
  localparam logic [7:0] BSET_MASK = 8'hf1;
  localparam logic [7:0] BSET_PATTERN = 8'h80;
  localparam logic [7:0] FILL_PATTERN = 8'h68;
  // operand field positions
  localparam int DEST_BIT = 1;
  localparam int ABANK_BIT = 0;
  localparam int BITSEL_LSB = 1;
  // indexed window limit and fill value
  localparam logic [7:0] OFFSET_LIMIT = 8'h5f;
  localparam logic [7:0] FILL_VALUE = 8'hff;
  // widths and reset values
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] NIBBLE_MAX = 4'hf;
  // execution phases of one instruction cycle
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;
  // decoded operation
  typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_BSET, OP_FILL} op_t;
endpackage

// *** src/indexed_literal_offset_decode.sv ***
// indexed literal offset decode and four-phase execute path
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Behaviour
// - enabled: offset up to 5Fh adds pointer
// - indexed only when enabled and access bit zero
// - indexed add: accumulator plus indexed byte
// - add decoded from 0010 01d0 pattern
// - d=0 to accumulator, d=1 to memory
// - add updates N, OV, C, DC, Z
// - bit-set sets bit b, flags untouched
// - fill writes FFh, flags untouched
// - one cycle: decode, read, process, write
// - extension bit defaults to disabled
// - effective address spans full 4096 bytes
// ----------------------------------------------------------------------------
module indexed_literal_offset_decode (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic extension_enable_bit, // configuration bit, sampled after reset
  input wire logic instr_valid, // new instruction word offered at decode
  input wire logic [15:0] instr_word, // opcode byte then offset byte
  input wire logic [11:0] stack_frame_pointer, // read only here
  input wire logic [7:0] mem_rdata, // data byte at mem_addr
  output logic instr_ready, // high in decode phase
  output logic [11:0] mem_addr, // data address
  output logic mem_we, // write strobe, high in the cycle after the write phase
  output logic [7:0] mem_wdata, // write data
  output logic [7:0] accumulator, // working accumulator
  output logic negative_flag,
  output logic overflow_flag,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic indexed_hit // last instruction used indexed addressing
);
  // --------------------------------------------------------------------------
  // reset synchroniser
  // --------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_b_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b_r <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  idx_decode_pkg::phase_t phase_r, phase_nxt; // current phase
  idx_decode_pkg::op_t op_r, op_nxt; // decoded operation
  logic ext_en_r, ext_en_nxt; // latched extension enable
  logic [15:0] iw_r, iw_nxt; // held instruction word
  logic [11:0] addr_r, addr_nxt;
  logic [7:0] opnd_r, opnd_nxt; // operand byte read in
  logic [7:0] res_r, res_nxt; // processed result
  logic we_r, we_nxt;
  logic rdy_r, rdy_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [4:0] flags_r, flags_nxt; // {n, ov, c, dc, z}
  logic hit_r, hit_nxt;

  // decode helpers (combinational views of the held word)
  logic [7:0] opc;
  logic [7:0] ofs;
  logic use_indexed;
  logic [8:0] sum9;
  logic [4:0] low5;
  assign opc = iw_r[15:8];
  assign ofs = iw_r[7:0];
  // indexed only with extension on, access bit clear, offset in window
  assign use_indexed = ext_en_r && !opc[idx_decode_pkg::ABANK_BIT]
                       && (ofs <= idx_decode_pkg::OFFSET_LIMIT);
  assign sum9 = {1'b0, acc_r} + {1'b0, opnd_r};
  assign low5 = {1'b0, acc_r[3:0]} + {1'b0, opnd_r[3:0]};

  // --------------------------------------------------------------------------
  // next-state logic: one phase per clock, four per instruction cycle
  // --------------------------------------------------------------------------
  always_comb begin
    phase_nxt = phase_r;
    op_nxt = op_r;
    ext_en_nxt = ext_en_r;
    iw_nxt = iw_r;
    addr_nxt = addr_r;
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    we_nxt = 1'b0;
    rdy_nxt = 1'b0;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    hit_nxt = hit_r;
    unique case (phase_r)
      idx_decode_pkg::PH_DECODE: begin
        rdy_nxt = 1'b1;
        // only taken while ready is shown, so the first armed cycle refuses a word
        if (instr_valid && rdy_r) begin
          iw_nxt = instr_word;
          rdy_nxt = 1'b0;
          phase_nxt = idx_decode_pkg::PH_READ;
          // classify opcode byte; a non-matching word runs as a no-op
          if ((instr_word[15:8] & idx_decode_pkg::ADD_MASK) == idx_decode_pkg::ADD_PATTERN) begin
            op_nxt = idx_decode_pkg::OP_ADD;
          end else if ((instr_word[15:8] & idx_decode_pkg::BSET_MASK) == idx_decode_pkg::BSET_PATTERN) begin
            op_nxt = idx_decode_pkg::OP_BSET;
          end else if (instr_word[15:8] == idx_decode_pkg::FILL_PATTERN) begin
            op_nxt = idx_decode_pkg::OP_FILL;
          end else begin
            op_nxt = idx_decode_pkg::OP_NONE;
          end
        end
      end
      idx_decode_pkg::PH_READ: begin
        // pointer plus offset, full 12-bit wrap across data space
        if (use_indexed) begin
          addr_nxt = stack_frame_pointer + {4'h0, ofs};
        end else begin
          addr_nxt = {4'h0, ofs}; // direct access-bank meaning
        end
        hit_nxt = use_indexed;
        phase_nxt = idx_decode_pkg::PH_PROCESS;
      end
      idx_decode_pkg::PH_PROCESS: begin
        opnd_nxt = mem_rdata; // address stable since read phase
        phase_nxt = idx_decode_pkg::PH_WRITE;
      end
      idx_decode_pkg::PH_WRITE: begin
        phase_nxt = idx_decode_pkg::PH_DECODE;
        rdy_nxt = 1'b1;
        unique case (op_r)
          idx_decode_pkg::OP_ADD: begin
            res_nxt = sum9[7:0];
            flags_nxt = {sum9[7], (acc_r[7] == opnd_r[7]) && (sum9[7] != acc_r[7]),
                         sum9[8], low5[4], sum9[7:0] == idx_decode_pkg::BYTE_RESET};
            if (iw_r[8 + idx_decode_pkg::DEST_BIT]) begin
              we_nxt = 1'b1;
            end else begin
              acc_nxt = sum9[7:0];
            end
          end
          idx_decode_pkg::OP_BSET: begin
            res_nxt = opnd_r | (8'h01 << opc[idx_decode_pkg::BITSEL_LSB +: 3]);
            we_nxt = 1'b1;
          end
          idx_decode_pkg::OP_FILL: begin
            res_nxt = idx_decode_pkg::FILL_VALUE;
            we_nxt = 1'b1;
          end
          idx_decode_pkg::OP_NONE: begin
            we_nxt = 1'b0;
          end
        endcase
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // registers; extension bit caught once, at first edge after reset release
  // --------------------------------------------------------------------------
  logic armed_r;
  always_ff @(posedge clock or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      phase_r <= idx_decode_pkg::PH_DECODE;
      op_r <= idx_decode_pkg::OP_NONE;
      ext_en_r <= 1'b0;
      armed_r <= 1'b0;
      iw_r <= 16'h0000;
      addr_r <= idx_decode_pkg::ADDR_RESET;
      opnd_r <= idx_decode_pkg::BYTE_RESET;
      res_r <= idx_decode_pkg::BYTE_RESET;
      we_r <= 1'b0;
      rdy_r <= 1'b0;
      acc_r <= idx_decode_pkg::BYTE_RESET;
      flags_r <= idx_decode_pkg::FLAGS_RESET;
      hit_r <= 1'b0;
    end else begin
      phase_r <= armed_r ? phase_nxt : idx_decode_pkg::PH_DECODE;
      op_r <= op_nxt;
      ext_en_r <= armed_r ? ext_en_nxt : extension_enable_bit;
      armed_r <= 1'b1;
      iw_r <= iw_nxt;
      addr_r <= addr_nxt;
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      we_r <= we_nxt;
      rdy_r <= armed_r ? rdy_nxt : 1'b0;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      hit_r <= hit_nxt;
    end
  end

  // outputs straight from flip-flops; the pointer is never driven
  assign instr_ready = rdy_r;
  assign mem_addr = addr_r;
  assign mem_we = we_r;
  assign mem_wdata = res_r;
  assign accumulator = acc_r;
  assign {negative_flag, overflow_flag, carry_flag, digit_carry_flag, zero_flag} = flags_r;
  assign indexed_hit = hit_r;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_idx_addr;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_READ && use_indexed) |=> mem_addr == $past(stack_frame_pointer) + {4'h0, $past(ofs)};
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");
  property p_direct;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_READ && !ext_en_r) |=> !indexed_hit && mem_addr[11:8] == 4'h0;
  endproperty
  a_direct: assert property (p_direct) else $error("indexed used while disabled");
  property p_cycle;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_DECODE && instr_valid && instr_ready) |=> ##2 phase_r == idx_decode_pkg::PH_WRITE ##1 instr_ready;
  endproperty
  a_cycle: assert property (p_cycle) else $error("instruction not four phases");
  property p_fill;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_WRITE && op_r == idx_decode_pkg::OP_FILL) |=> mem_we && mem_wdata == 8'hff && $stable(flags_r);
  endproperty
  a_fill: assert property (p_fill) else $error("fill wrong");
  property p_bset;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_WRITE && op_r == idx_decode_pkg::OP_BSET) |=> mem_we && mem_wdata[$past(opc[3:1])] && $stable(flags_r);
  endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");
  property p_add_dest;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_WRITE && op_r == idx_decode_pkg::OP_ADD) |=> mem_we == $past(iw_r[9]);
  endproperty
  a_add_dest: assert property (p_add_dest) else $error("add destination wrong");
  property p_add_val;
    @(posedge clock) disable iff (!rst_sync_b_r)
    (phase_r == idx_decode_pkg::PH_WRITE && op_r == idx_decode_pkg::OP_ADD && !iw_r[9]) |=> accumulator == $past(acc_r) + $past(opnd_r);
  endproperty
  a_add_val: assert property (p_add_val) else $error("add sum wrong");
  property p_zero;
    @(posedge clock) disable iff (!rst_sync_b_r)
    $past(phase_r == idx_decode_pkg::PH_WRITE && op_r == idx_decode_pkg::OP_ADD) |-> zero_flag == ($past(sum9[7:0]) == 8'h00) && carry_flag == $past(sum9[8]);
  endproperty
  a_zero: assert property (p_zero) else $error("add flags wrong");
endmodule // indexed_literal_offset_decode

// *** bench/indexed_literal_offset_decode_tb.sv ***
// self-checking bench for the indexed literal offset decode path
`timescale 1ns/1ps
module indexed_literal_offset_decode_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock;
  logic rst_b;
  logic extension_enable_bit;
  logic instr_valid;
  logic [15:0] instr_word;
  logic [11:0] stack_frame_pointer;
  logic [7:0] mem_rdata; // bench stands in for the data memory
  logic instr_ready;
  logic [11:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] accumulator;
  logic negative_flag, overflow_flag, carry_flag, digit_carry_flag, zero_flag;
  logic indexed_hit;
  int errors;
  int checks_done;
  int cycles;
  logic [7:0] ea; // expected accumulator
  logic [4:0] ef; // expected flags, n ov c dc z
  logic [12:0] r;
  // ---------------------------------------------------------------
  // design under test
  // ---------------------------------------------------------------
  indexed_literal_offset_decode dut_u (
    .clock(clock), .rst_b(rst_b), .extension_enable_bit(extension_enable_bit),
    .instr_valid(instr_valid), .instr_word(instr_word), .stack_frame_pointer(stack_frame_pointer),
    .mem_rdata(mem_rdata), .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .accumulator(accumulator), .negative_flag(negative_flag),
    .overflow_flag(overflow_flag), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag), .indexed_hit(indexed_hit));
  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // generous ceiling, the whole run needs well under 300 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // reference adder: flags then sum, worked out independently
  function automatic logic [12:0] addf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    logic dc;
    t = {1'b0, a} + {1'b0, b};
    dc = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
    return {t[7], (a[7] == b[7]) && (t[7] != a[7]), t[8], dc, t[7:0] == 8'h00, t[7:0]};
  endfunction
  // one compare for every value result, widened to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reset with the extension bit held, since it is only sampled at release
  task automatic do_reset(input logic ext);
    rst_b <= 1'b0;
    extension_enable_bit <= ext;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    ea = 8'h00;
    ef = 5'h00;
  endtask
  // one instruction: offer, wait three edges past take, check while the write stands
  task automatic run(input logic [15:0] w, input logic [11:0] fp, input logic [7:0] rd,
                     input logic e_we, input logic [11:0] e_addr, input logic [7:0] e_wd, input logic e_hit);
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    stack_frame_pointer <= fp;
    mem_rdata <= rd;
    @(posedge clock);
    instr_valid <= 1'b0; // this edge takes it
    #1;
    chk({15'h0, instr_ready}, 16'h0000);
    // write pulse lands on the third edge after the take and stands one cycle
    repeat (3) @(posedge clock);
    #1;
    chk({15'h0, instr_ready}, 16'h0001);
    chk({4'h0, mem_addr}, {4'h0, e_addr});
    chk({15'h0, indexed_hit}, {15'h0, e_hit});
    chk({15'h0, mem_we}, {15'h0, e_we});
    if (e_we) chk({8'h00, mem_wdata}, {8'h00, e_wd});
    chk({8'h00, accumulator}, {8'h00, ea});
    chk({11'h0, negative_flag, overflow_flag, carry_flag, digit_carry_flag, zero_flag}, {11'h0, ef});
  endtask
  // closing report, the single exit point
  task automatic end_of_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    extension_enable_bit = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    stack_frame_pointer = 12'h000;
    mem_rdata = 8'h00;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    do_reset(1'b1);
    // add into accumulator twice, then back to memory with carry out
    r = addf(ea, 8'h17);
    ea = r[7:0];
    ef = r[12:8];
    run(16'h242c, 12'ha00, 8'h17, 1'b0, 12'ha2c, 8'h00, 1'b1);
    r = addf(ea, 8'h20);
    ea = r[7:0];
    ef = r[12:8];
    run(16'h242c, 12'ha00, 8'h20, 1'b0, 12'ha2c, 8'h00, 1'b1);
    r = addf(ea, 8'hc9);
    ef = r[12:8];
    // top offset with pointer near the end wraps inside the 12-bit space
    run(16'h265f, 12'hfff, 8'hc9, 1'b1, 12'h05e, r[7:0], 1'b1);
    // positive plus positive giving a negative result: sign and overflow set
    r = addf(ea, 8'h50);
    ea = r[7:0];
    ef = r[12:8];
    run(16'h2430, 12'h100, 8'h50, 1'b0, 12'h130, 8'h00, 1'b1);
    // every bit position, flags must stay put
    for (int b = 0; b < 8; b++) begin
      run({4'h8, b[2:0], 1'b0, 8'h0a}, 12'ha00, 8'h55, 1'b1, 12'ha0a, 8'h55 | (8'h01 << b), 1'b1);
    end
    run(16'h682c, 12'ha00, 8'h00, 1'b1, 12'ha2c, 8'hff, 1'b1);
    // first offset past the indexed window is a direct address
    run(16'h6860, 12'ha00, 8'h00, 1'b1, 12'h060, 8'hff, 1'b0);
    // access bit set: no indexed form, runs as a no-op
    run(16'h2510, 12'ha00, 8'h33, 1'b0, 12'h010, 8'h00, 1'b0);
    // extension off: same fill goes to the direct address
    @(posedge clock);
    do_reset(1'b0);
    run(16'h682c, 12'ha00, 8'h00, 1'b1, 12'h02c, 8'hff, 1'b0);
    end_of_test();
  end
endmodule // indexed_literal_offset_decode_tb
